// file: hw/rest_mode_timing_control.sv
`timescale 1ns/100ps
`default_nettype none
module rest_mode_timing_control #(
    parameter int slow_cycles = rest_timing_pkg::slow_tick_cycles,
    parameter int pos_cycles = rest_timing_pkg::pos_tick_cycles,
    parameter logic [7:0] revision_code = 8'h00 // Arbitrary value
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port from serial engine
    input wire rest_timing_pkg::reg_req_t req,
    output logic [7:0] rdata,
    // Settings owned by neighbouring blocks
    input wire logic [7:0] run_downshift_count,
    input wire logic [7:0] first_rest_period,
    // Motion from the navigation core
    input wire logic motion_seen,
    // Status
    output rest_timing_pkg::power_state_t power_state,
    output logic sample_strobe,
    output logic chip_reset_req
);
    ////////////////////////////////////////////////////////////////
    logic [7:0] down1_r, down1_nxt, per2_r, per2_nxt;
    logic [7:0] down2_r, down2_nxt, per3_r, per3_nxt;
    logic [7:0] force_r, force_nxt, rdata_nxt;
    logic chip_reset_nxt;
    logic slow_tick, pos_tick;

    tick_divider #(.count(slow_cycles)) u_slow (
        .core_clk(core_clk),
        .resetn(resetn),
        .tick(slow_tick)
    );
    tick_divider #(.count(pos_cycles)) u_pos (
        .core_clk(core_clk),
        .resetn(resetn),
        .tick(pos_tick)
    );

    always_comb begin
        down1_nxt = down1_r;
        per2_nxt = per2_r;
        down2_nxt = down2_r;
        per3_nxt = per3_r;
        force_nxt = force_r;
        chip_reset_nxt = 1'b0;
        rdata_nxt = rdata;
        // Out-of-mode rewrites take effect at next count reload
        if (req.wr) begin
            if (req.addr == rest_timing_pkg::first_downshift_addr) begin
                down1_nxt = req.wdata;
            end else if (req.addr == rest_timing_pkg::second_period_addr) begin
                per2_nxt = req.wdata;
            end else if (req.addr == rest_timing_pkg::second_downshift_addr)
            begin
                down2_nxt = req.wdata;
            end else if (req.addr == rest_timing_pkg::third_period_addr) begin
                per3_nxt = req.wdata;
            end else if (req.addr == rest_timing_pkg::forced_mode_addr) begin
                force_nxt = req.wdata & rest_timing_pkg::force_field_mask;
            end else if (req.addr == rest_timing_pkg::chip_reset_addr) begin
                chip_reset_nxt = (req.wdata == rest_timing_pkg::chip_reset_key);
            end
        end
        if (req.rd) begin
            if (req.addr == rest_timing_pkg::first_downshift_addr) begin
                rdata_nxt = down1_r;
            end else if (req.addr == rest_timing_pkg::second_period_addr) begin
                rdata_nxt = per2_r;
            end else if (req.addr == rest_timing_pkg::second_downshift_addr)
            begin
                rdata_nxt = down2_r;
            end else if (req.addr == rest_timing_pkg::third_period_addr) begin
                rdata_nxt = per3_r;
            end else if (req.addr == rest_timing_pkg::forced_mode_addr) begin
                rdata_nxt = force_r;
            end else if (req.addr == rest_timing_pkg::inverted_rev_addr) begin
                rdata_nxt = ~revision_code;
            end else begin
                // Write-only and unmapped read as zero
                rdata_nxt = 8'h00;
            end
        end
    end

    // The soft reset reinitialises this block too, two cycles after the key
    always_ff @(posedge core_clk) begin
        if (!resetn || chip_reset_req) begin
            down1_r <= rest_timing_pkg::first_downshift_rst;
            per2_r <= rest_timing_pkg::second_period_rst;
            down2_r <= rest_timing_pkg::second_downshift_rst;
            per3_r <= rest_timing_pkg::third_period_rst;
            force_r <= rest_timing_pkg::forced_mode_rst;
            rdata <= 8'h00;
        end else begin
            down1_r <= down1_nxt;
            per2_r <= per2_nxt;
            down2_r <= down2_nxt;
            per3_r <= per3_nxt;
            force_r <= force_nxt;
            rdata <= rdata_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            chip_reset_req <= 1'b0;
        end else begin
            chip_reset_req <= chip_reset_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Power-state sequencer
    rest_timing_pkg::power_state_t state_r, state_nxt, auto_nxt;
    logic [7:0] per_cnt_r, per_cnt_nxt;
    logic [15:0] down_cnt_r, down_cnt_nxt;
    logic [2:0] force_code;
    logic [7:0] cur_period;
    logic [15:0] cur_down;
    logic period_done, sample_nxt, tick;

    assign force_code = force_r[rest_timing_pkg::force_lsb +: 3];

    always_comb begin
        cur_period = 8'h00;
        cur_down = 16'h0;
        tick = slow_tick;
        case (state_r)
            rest_timing_pkg::st_first_rest_mode: begin
                cur_period = first_rest_period;
                cur_down = 16'(down1_r) << rest_timing_pkg::first_shift;
            end
            rest_timing_pkg::st_second_rest_mode: begin
                cur_period = per2_r;
                cur_down = 16'(down2_r) << rest_timing_pkg::second_shift;
            end
            rest_timing_pkg::st_third_rest_mode: begin
                cur_period = per3_r;
            end
            default: begin
                tick = pos_tick;
                cur_down = 16'(run_downshift_count) << rest_timing_pkg::run_shift;
            end
        endcase
    end

    assign period_done = tick && (per_cnt_r == cur_period);

    always_comb begin
        auto_nxt = state_r;
        per_cnt_nxt = per_cnt_r;
        down_cnt_nxt = down_cnt_r;
        sample_nxt = period_done;
        if (period_done) begin
            per_cnt_nxt = 8'h00;
            down_cnt_nxt = down_cnt_r + 16'h1;
        end else if (tick) begin
            per_cnt_nxt = per_cnt_r + 8'h1;
        end
        // Motion restarts the downshift wait, else a stale count steps early
        if (motion_seen) begin
            down_cnt_nxt = 16'h0;
        end
        // Each period counts as one sample; downshift counts periods
        if (motion_seen) begin
            auto_nxt = rest_timing_pkg::st_run;
        end else if (period_done && down_cnt_r + 16'h1 >= cur_down) begin
            case (state_r)
                rest_timing_pkg::st_first_rest_mode: auto_nxt = rest_timing_pkg::st_second_rest_mode;
                rest_timing_pkg::st_second_rest_mode: auto_nxt = rest_timing_pkg::st_third_rest_mode;
                rest_timing_pkg::st_third_rest_mode: auto_nxt = rest_timing_pkg::st_third_rest_mode;
                default: auto_nxt = rest_timing_pkg::st_first_rest_mode;
            endcase
        end
        case (force_code)
            3'd1: state_nxt = rest_timing_pkg::st_first_rest_mode;
            3'd2: state_nxt = rest_timing_pkg::st_second_rest_mode;
            3'd3: state_nxt = rest_timing_pkg::st_third_rest_mode;
            3'd4: state_nxt = rest_timing_pkg::st_run;
            3'd5: state_nxt = rest_timing_pkg::st_run2;
            3'd6: state_nxt = rest_timing_pkg::st_idle;
            default: state_nxt = auto_nxt;
        endcase
        if (state_nxt != state_r) begin
            per_cnt_nxt = 8'h00;
            down_cnt_nxt = 16'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn || chip_reset_req) begin
            state_r <= rest_timing_pkg::st_run;
            per_cnt_r <= 8'h00;
            down_cnt_r <= 16'h0;
            sample_strobe <= 1'b0;
        end else begin
            state_r <= state_nxt;
            per_cnt_r <= per_cnt_nxt;
            down_cnt_r <= down_cnt_nxt;
            sample_strobe <= sample_nxt;
        end
    end

    assign power_state = state_r;

    ////////////////////////////////////////////////////////////////
    property p_reset_key;
        @(posedge core_clk) disable iff (!resetn)
        (req.wr && req.addr == rest_timing_pkg::chip_reset_addr
            && req.wdata == rest_timing_pkg::chip_reset_key)
        |=> chip_reset_req ##1 (force_r == 8'h00
            && state_r == rest_timing_pkg::st_run);
    endproperty
    a_reset_key: assert property (p_reset_key)
        else $error("chip reset key did not reset");

    property p_no_false_reset;
        @(posedge core_clk) disable iff (!resetn)
        !(req.wr && req.addr == rest_timing_pkg::chip_reset_addr
            && req.wdata == rest_timing_pkg::chip_reset_key) |=> !chip_reset_req;
    endproperty
    a_no_false_reset: assert property (p_no_false_reset)
        else $error("spurious chip reset");

    property p_inv_rev;
        @(posedge core_clk) disable iff (!resetn)
        (req.rd && req.addr == rest_timing_pkg::inverted_rev_addr)
        |=> rdata == ~revision_code;
    endproperty
    a_inv_rev: assert property (p_inv_rev)
        else $error("inverted revision wrong");

    property p_force_rsvd;
        @(posedge core_clk) disable iff (!resetn)
        (force_r & ~rest_timing_pkg::force_field_mask) == 8'h00;
    endproperty
    a_force_rsvd: assert property (p_force_rsvd)
        else $error("reserved forced-mode bits set");

    property p_force_third_rest_mode;
        @(posedge core_clk) disable iff (!resetn || chip_reset_req)
        (force_r[6:4] == 3'd3) |=> state_r == rest_timing_pkg::st_third_rest_mode;
    endproperty
    a_force_third_rest_mode: assert property (p_force_third_rest_mode)
        else $error("forced third rest not entered");

    property p_force_idle;
        @(posedge core_clk) disable iff (!resetn || chip_reset_req)
        (force_r[6:4] == 3'd6) |=> state_r == rest_timing_pkg::st_idle;
    endproperty
    a_force_idle: assert property (p_force_idle)
        else $error("forced idle not entered");

    property p_motion_run;
        @(posedge core_clk) disable iff (!resetn || chip_reset_req)
        (motion_seen && force_code == 3'd0 && force_nxt[6:4] == 3'd0)
        |=> state_r == rest_timing_pkg::st_run;
    endproperty
    a_motion_run: assert property (p_motion_run)
        else $error("motion did not return to run");

    property p_per_bound;
        @(posedge core_clk) disable iff (!resetn)
        state_r == rest_timing_pkg::st_second_rest_mode && $stable(state_r)
        |-> per_cnt_r <= per2_r;
    endproperty
    a_per_bound: assert property (p_per_bound)
        else $error("second rest period overrun");

    property p_step12;
        @(posedge core_clk) disable iff (!resetn || chip_reset_req)
        ($past(state_r) == rest_timing_pkg::st_first_rest_mode
            && state_r == rest_timing_pkg::st_second_rest_mode && force_code == 3'd0)
        |-> $past(down_cnt_r) + 16'h1
            >= 16'(down1_r) << rest_timing_pkg::first_shift;
    endproperty
    a_step12: assert property (p_step12)
        else $error("early first downshift");

    c_second_rest_mode: cover property (@(posedge core_clk)
        state_r == rest_timing_pkg::st_second_rest_mode);
    c_third_rest_mode: cover property (@(posedge core_clk)
        state_r == rest_timing_pkg::st_third_rest_mode);
    c_reset: cover property (@(posedge core_clk) chip_reset_req);
endmodule
`default_nettype wire

// file: shared/rest_timing_pkg.sv
package rest_timing_pkg;

    // Register offsets
    localparam logic [6:0] first_downshift_addr = 7'h10;
    localparam logic [6:0] second_period_addr = 7'h11;
    localparam logic [6:0] second_downshift_addr = 7'h12;
    localparam logic [6:0] third_period_addr = 7'h13;
    localparam logic [6:0] forced_mode_addr = 7'h22;
    localparam logic [6:0] chip_reset_addr = 7'h3a;
    localparam logic [6:0] inverted_rev_addr = 7'h3f;

    // Reset values and the chip reset key
    localparam logic [7:0] first_downshift_rst = 8'h1f;
    localparam logic [7:0] second_period_rst = 8'h09;
    localparam logic [7:0] second_downshift_rst = 8'h2f;
    localparam logic [7:0] third_period_rst = 8'h31;
    localparam logic [7:0] forced_mode_rst = 8'h00;
    localparam logic [7:0] chip_reset_key = 8'h5a;

    // Forced-mode field
    localparam int force_lsb = 4;
    localparam logic [7:0] force_field_mask = 8'h70;

    // Downshift multipliers, as shift amounts
    localparam int run_shift = 3;
    localparam int first_shift = 4;
    localparam int second_shift = 7;

    // Timing: slow clock 10 ms, position period 4 ms, core 100 MHz
    localparam int clk_period_ns = 10;
    localparam int slow_tick_ms = 10;
    localparam int pos_tick_ms = 4;
    localparam int slow_tick_cycles = slow_tick_ms * 1000000 / clk_period_ns;
    localparam int pos_tick_cycles = pos_tick_ms * 1000000 / clk_period_ns;

    typedef enum logic [2:0] {
        st_run = 3'b000,
        st_first_rest_mode = 3'b001,
        st_second_rest_mode = 3'b011,
        st_third_rest_mode = 3'b010,
        st_run2 = 3'b110,
        st_idle = 3'b111
    } power_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// file: hw/tick_divider.sv
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
    parameter int count = 10
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Tick out
    output logic tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + 32'h1;
        if (cnt_r == 32'(count - 1)) begin
            cnt_nxt = 32'h0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// file: verification/serial_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
    // Clock
    input wire logic core_clk,
    // Register port toward the sensor
    output var rest_timing_pkg::reg_req_t req,
    input wire logic [7:0] rdata
);
    initial begin
        req = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Released address and data show inverted values, never a stale copy; wr and rd drop to zero
    task automatic send(input logic w, input logic [6:0] a,
        input logic [7:0] d);
        @(posedge core_clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
        send(1'b1, a, d);
    endtask

    task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
        send(1'b0, a, 8'h00);
        #1;
        d = rdata;
    endtask

    task automatic guarded_write(input logic [6:0] a, input logic [7:0] d);
        write_reg(rest_timing_pkg::forced_mode_addr, 8'h40);
        write_reg(a, d);
        write_reg(rest_timing_pkg::forced_mode_addr, 8'h00);
    endtask

    task automatic chip_reset();
        write_reg(rest_timing_pkg::chip_reset_addr, 8'h5a);
    endtask
endmodule
`default_nettype wire

// file: verification/rest_mode_timing_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rest_mode_timing_control_bench;
    localparam int slow = 4;
    logic core_clk;
    logic resetn;
    rest_timing_pkg::reg_req_t req;
    logic [7:0] rdata;
    logic [7:0] run_downshift_count;
    logic [7:0] first_rest_period;
    logic motion_seen;
    rest_timing_pkg::power_state_t power_state;
    logic sample_strobe;
    logic chip_reset_req;
    rest_timing_pkg::power_state_t exp_state [8];
    logic [6:0] rw_addr [4];
    logic [7:0] rw_rst [4];
    int per_exp [4];
    int n_fail;
    int n_compared;
    int n_pulse;
    int gap;
    int i;
    logic [7:0] d;

    // Revision value is arbitrary
    rest_mode_timing_control #(.slow_cycles(slow), .pos_cycles(2),
        .revision_code(8'h3c)) u_rest_mode_timing_control (
        .core_clk(core_clk), .resetn(resetn), .req(req), .rdata(rdata),
        .run_downshift_count(run_downshift_count),
        .first_rest_period(first_rest_period), .motion_seen(motion_seen),
        .power_state(power_state), .sample_strobe(sample_strobe),
        .chip_reset_req(chip_reset_req));

    serial_host_model u_serial_host_model (
        .core_clk(core_clk), .req(req), .rdata(rdata));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (chip_reset_req === 1'b1) begin
            n_pulse <= n_pulse + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("Compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic rd_check(input string name, input logic [6:0] a,
        input logic [7:0] exp);
        u_serial_host_model.read_reg(a, d);
        check(name, d, exp);
    endtask

    task automatic step(inout int n, input int bound);
        @(posedge core_clk);
        #1;
        n++;
        if (n > bound) begin
            n_fail++;
            $display("Error wait timed out");
            results();
        end
    endtask

    task automatic wait_state(input rest_timing_pkg::power_state_t s,
        input int bound);
        gap = 0;
        while (power_state !== s) begin
            step(gap, bound);
        end
    endtask

    // Old-mode strobe and first new period may be partial; last gap counts
    task automatic strobe_gap();
        int k;
        for (k = 0; k < 3; k++) begin
            gap = 0;
            do begin
                step(gap, 400);
            end while (sample_strobe !== 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        run_downshift_count = 8'h01;
        first_rest_period = 8'h02;
        motion_seen = 1'b1;
        n_fail = 0;
        n_compared = 0;
        n_pulse = 0;
        exp_state = '{rest_timing_pkg::st_run, rest_timing_pkg::st_first_rest_mode,
            rest_timing_pkg::st_second_rest_mode, rest_timing_pkg::st_third_rest_mode,
            rest_timing_pkg::st_run, rest_timing_pkg::st_run2,
            rest_timing_pkg::st_idle, rest_timing_pkg::st_run};
        rw_addr = '{7'h10, 7'h11, 7'h12, 7'h13};
        rw_rst = '{8'h1f, 8'h09, 8'h2f, 8'h31};
        per_exp = '{0, 3 * slow, 4 * slow, 6 * slow};
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            rd_check("reset value", rw_addr[i], rw_rst[i]);
            u_serial_host_model.write_reg(rw_addr[i], 8'(8'hc3 ^ i));
            rd_check("readback", rw_addr[i], 8'(8'hc3 ^ i));
        end
        rd_check("forced reset", 7'h22, 8'h00);
        u_serial_host_model.write_reg(7'h22, 8'hff);
        rd_check("forced mask", 7'h22, 8'h70);
        rd_check("inverted rev", 7'h3f, 8'hc3);
        u_serial_host_model.write_reg(7'h3f, 8'h00);
        rd_check("inverted rev ro", 7'h3f, 8'hc3);
        rd_check("reset reg read", 7'h3a, 8'h00);
        rd_check("unmapped", 7'h20, 8'h00);
        u_serial_host_model.write_reg(7'h11, 8'h03);
        u_serial_host_model.write_reg(7'h13, 8'h05);
        for (i = 1; i < 4; i++) begin
            u_serial_host_model.write_reg(7'h22, 8'(i << 4));
            strobe_gap();
            check("sample period", 8'(gap), 8'(per_exp[i]));
        end
        for (i = 0; i < 8; i++) begin
            u_serial_host_model.write_reg(7'h22, 8'(i << 4));
            repeat (3) @(posedge core_clk);
            #1;
            check("forced state", {5'h00, power_state}, {5'h00, exp_state[i]});
        end
        first_rest_period <= 8'h01;
        u_serial_host_model.guarded_write(7'h10, 8'h01);
        u_serial_host_model.guarded_write(7'h11, 8'h01);
        u_serial_host_model.guarded_write(7'h12, 8'h01);
        motion_seen <= 1'b0;
        wait_state(rest_timing_pkg::st_first_rest_mode, 100);
        check("run downshift", 8'(gap >= 12 && gap <= 20), 8'h01);
        wait_state(rest_timing_pkg::st_second_rest_mode, 400);
        check("first_rest_downshift_count", 8'(gap >= 118 && gap <= 138), 8'h01);
        wait_state(rest_timing_pkg::st_third_rest_mode, 2000);
        check("second_rest_downshift_count", 8'(gap >= 1014 && gap <= 1034), 8'h01);
        motion_seen <= 1'b1;
        wait_state(rest_timing_pkg::st_run, 3);
        check("motion return", 8'(gap <= 2), 8'h01);
        u_serial_host_model.write_reg(7'h3a, 8'h11);
        repeat (3) @(posedge core_clk);
        check("no reset pulse", 8'(n_pulse), 8'h00);
        rd_check("kept", 7'h11, 8'h01);
        u_serial_host_model.chip_reset();
        repeat (3) @(posedge core_clk);
        check("reset pulse", 8'(n_pulse), 8'h01);
        rd_check("restored", 7'h11, 8'h09);
        results();
    end
endmodule
`default_nettype wire
